// ===== rtl/cbt_regs.sv
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
// Function
// RULE1: transmit error tally reads in bits 15-8 of error_counters, read only.
// RULE2: receive error tally reads in bits 7-0 of error_counters, read only.
// RULE3: resync jump width is code plus one quanta, one to four.
// RULE4: quantum equals two times prescaler code plus one module clocks.
// RULE5: free phase two length is code plus one quanta, one to eight.
// RULE6: phase two is programmed length, or max of phase one and processing time.
// RULE7: sample mode one takes three samples at sample point, else one.
// RULE8: phase one length is code plus one quanta, one to eight.
// RULE9: propagation length is code plus one quanta, one to eight.
// RULE10: wake filter select routes wake detection through the line filter.
// RULE11: sixteen filter enables, bit n for filter n, all reset to one.
// RULE12: dest code 0-14 selects receive buffer, code 15 the receive FIFO.
// RULE13: four dest fields per register, lowest filter in bits 3-0, reset zero.
// RULE14: accepted message reports matching filter number in a 5-bit field.
// RULE15: bit is sync plus propagation, phase one, phase two; sample ends phase one.
module cbt_regs (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 can_rx,
  input  wire logic [7:0]           tx_fault_tally,
  input  wire logic [7:0]           rx_fault_tally,
  input  wire logic                 hit_valid,
  input  wire logic [3:0]           hit_index,
  output logic [15:0]               filter_accept_enable,
  output cbt_pkg::cbt_route_t       route,
  output logic [4:0]                matched_filter_index,
  output cbt_pkg::cbt_timing_t      timing,
  output logic                      tq_tick,
  output logic                      sample_pt,
  output logic                      bit_end,
  output logic                      bus_bit,
  output logic                      wake_detect,
  output logic [4:0]                phase_two_eff
);
  import cbt_pkg::*;

  typedef enum {
    REG_ERRCNT,
    REG_CFG_A,
    REG_CFG_B,
    REG_FEN,
    REG_DEST,
    REG_HIT,
    REG_NONE
  } cbt_sel_t;

  logic        aw_held;
  logic [7:0]  aw_addr;
  logic        w_held;
  logic [15:0] w_data;
  logic [1:0]  w_strb;
  logic        wr_go;
  cbt_sel_t    wr_sel;
  logic [1:0]  wr_didx;
  logic        ar_fire;
  logic        rx_meta;
  logic        rx_sync;
  logic        accepted;

  cbt_cfg_a_t  cfg_a;
  cbt_cfg_b_t  cfg_b;
  logic [15:0] dest_reg [NUM_DEST_REG];

  // address decode shared by the read and the write path
  function automatic cbt_sel_t decode(input logic [7:0] addr);
    cbt_sel_t sel;
    sel = REG_NONE;
    if (addr[1:0] != 2'h0) begin
      sel = REG_NONE;
    end else if (addr == OFF_ERRCNT) begin
      sel = REG_ERRCNT;
    end else if (addr == OFF_CFG_A) begin
      sel = REG_CFG_A;
    end else if (addr == OFF_CFG_B) begin
      sel = REG_CFG_B;
    end else if (addr == OFF_FEN) begin
      sel = REG_FEN;
    end else if (addr >= OFF_DEST0 && addr <= OFF_DEST3) begin
      sel = REG_DEST;
    end else if (addr == OFF_HIT) begin
      sel = REG_HIT;
    end
    return sel;
  endfunction

  // only byte lanes 0 and 1 exist; other lanes are ignored
  function automatic logic [15:0] merge(
    input logic [15:0] old,
    input logic [15:0] data,
    input logic [1:0]  strb,
    input logic [15:0] wmask
  );
    logic [15:0] lane;
    lane = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
    return (old & ~lane) | (data & lane);
  endfunction

  function automatic logic [3:0] dest_of(input logic [3:0] idx);
    logic [15:0] word;
    word = dest_reg[idx[3:2]];
    return word[{idx[1:0], 2'h0} +: 4];  // [RULE13]
  endfunction

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_fire       = s_axi_arvalid && s_axi_arready;
  assign wr_go         = aw_held && w_held && !s_axi_bvalid;
  assign wr_sel        = decode(aw_addr);
  assign wr_didx       = aw_addr[3:2];
  assign accepted      = hit_valid && filter_accept_enable[hit_index];  // [RULE11]
  assign timing        = '{a: cfg_a, b: cfg_b};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && !aw_held) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      w_held <= 1'b0;
      w_data <= 16'h0000;
      w_strb <= 2'h0;
    end else if (s_axi_wvalid && !w_held) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata[15:0];
      w_strb <= s_axi_wstrb[1:0];
    end else if (wr_go) begin
      w_held <= 1'b0;
    end
  end

  // read-only and unmapped writes are answered with an error, no effect
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      if (wr_sel == REG_NONE || wr_sel == REG_ERRCNT || wr_sel == REG_HIT) begin
        s_axi_bresp <= RESP_SLVERR;
      end else begin
        s_axi_bresp <= RESP_OKAY;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_a <= CFG_A_RST;
      cfg_b <= CFG_B_RST;
    end else if (wr_go && wr_sel == REG_CFG_A) begin
      cfg_a <= merge(cfg_a, w_data, w_strb, CFG_A_WMASK);  // [RULE3] [RULE4]
    end else if (wr_go && wr_sel == REG_CFG_B) begin
      cfg_b <= merge(cfg_b, w_data, w_strb, CFG_B_WMASK);  // [RULE5] [RULE6] [RULE7]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      filter_accept_enable <= FEN_RST;  // [RULE11]
    end else if (wr_go && wr_sel == REG_FEN) begin
      filter_accept_enable <= merge(filter_accept_enable, w_data, w_strb, ALL_WMASK);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_DEST_REG; i++) begin
        dest_reg[i] <= DEST_RST;  // [RULE13]
      end
    end else if (wr_go && wr_sel == REG_DEST) begin
      dest_reg[wr_didx] <= merge(dest_reg[wr_didx], w_data, w_strb, ALL_WMASK);
    end
  end

  // disabled filters never route and never update the hit number
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      route <= '0;
      matched_filter_index <= 5'h00;
    end else begin
      route.valid <= accepted;
      if (accepted) begin
        route.dest <= dest_of(hit_index);  // [RULE12]
        route.fifo <= (dest_of(hit_index) == DEST_FIFO);  // [RULE12]
        matched_filter_index <= {1'b0, hit_index};  // [RULE14]
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      case (decode(s_axi_araddr))
        REG_ERRCNT: s_axi_rdata[15:0] <= {tx_fault_tally, rx_fault_tally};  // [RULE1] [RULE2]
        REG_CFG_A:  s_axi_rdata[15:0] <= cfg_a & CFG_A_WMASK;
        REG_CFG_B:  s_axi_rdata[15:0] <= cfg_b & CFG_B_WMASK;
        REG_FEN:    s_axi_rdata[15:0] <= filter_accept_enable;
        REG_DEST:   s_axi_rdata[15:0] <= dest_reg[s_axi_araddr[3:2]];
        REG_HIT:    s_axi_rdata[4:0] <= matched_filter_index;  // [RULE14]
        default:    s_axi_rresp <= RESP_SLVERR;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // bus pin is asynchronous to clk
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= can_rx;
      rx_sync <= rx_meta;
    end
  end

  cbt_bit_timer u_timer (
    .clk           (clk),
    .rst           (rst),
    .timing        (timing),
    .rx_line       (rx_sync),
    .tq_tick       (tq_tick),
    .sample_pt     (sample_pt),
    .bit_end       (bit_end),
    .bus_bit       (bus_bit),
    .wake_detect   (wake_detect),
    .phase_two_eff (phase_two_eff)
  );

  // helper: cycles between quantum ticks under stable settings
  logic [7:0] gap;
  logic       gap_ok;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap <= 8'h00;
      gap_ok <= 1'b0;
    end else if (wr_go) begin
      gap <= 8'h00;
      gap_ok <= 1'b0;
    end else if (tq_tick) begin
      gap <= 8'h01;
      gap_ok <= 1'b1;
    end else if (gap != 8'hFF) begin
      gap <= gap + 8'h01;
    end
  end

  // low field of the hit filter's group, to check packing apart from dest_of
  logic [3:0] lane0_dest;
  assign lane0_dest = dest_reg[hit_index[3:2]][3:0];

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  tx_tally_read_a: assert property (  // [RULE1]
    ar_fire && s_axi_araddr == OFF_ERRCNT
    |=> s_axi_rvalid && s_axi_rdata[15:8] == $past(tx_fault_tally)
        && s_axi_rdata[31:16] == 16'h0000)
    else $error("tx tally read wrong");
  rx_tally_read_a: assert property (  // [RULE2]
    ar_fire && s_axi_araddr == OFF_ERRCNT
    |=> s_axi_rdata[7:0] == $past(rx_fault_tally))
    else $error("rx tally read wrong");
  quantum_period_a: assert property (  // [RULE4]
    tq_tick && gap_ok && !$past(wr_go)
    |-> gap == {1'b0, cfg_a.quantum_prescaler, 1'b1} + 8'h01)
    else $error("quantum period wrong");
  enable_write_a: assert property (  // [RULE11]
    wr_go && wr_sel == REG_FEN && w_strb == 2'h3
    |=> filter_accept_enable == $past(w_data) && s_axi_bvalid)
    else $error("enable write lost");
  disabled_drop_a: assert property (  // [RULE11]
    hit_valid && !filter_accept_enable[hit_index] |=> !route.valid)
    else $error("disabled filter routed");
  route_fifo_a: assert property (  // [RULE12]
    route.valid |-> route.fifo == (route.dest == DEST_FIFO))
    else $error("fifo route mismatch");
  dest_pack_a: assert property (  // [RULE13]
    accepted && hit_index[1:0] == 2'h0
    |=> route.dest == $past(lane0_dest))
    else $error("dest field packing wrong");
  hit_number_a: assert property (  // [RULE14]
    accepted |=> route.valid && matched_filter_index == {1'b0, $past(hit_index)})
    else $error("hit number wrong");
  bad_addr_a: assert property (
    ar_fire && decode(s_axi_araddr) == REG_NONE
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read answer wrong");
  ro_write_a: assert property (  // [RULE1]
    wr_go && (wr_sel == REG_ERRCNT || wr_sel == REG_HIT)
    |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
    else $error("read-only write accepted");
  hit_read_a: assert property (  // [RULE14]
    ar_fire && s_axi_araddr == OFF_HIT
    |=> s_axi_rdata == {27'h0, $past(matched_filter_index)})
    else $error("hit number read wrong");
  read_busy_a: assert property (
    ar_fire |=> s_axi_rvalid && !s_axi_arready)
    else $error("read accepted twice");

  cfg_write_c: cover property (wr_go && wr_sel == REG_CFG_B);
  fifo_route_c: cover property (route.valid && route.fifo);
  buffer_route_c: cover property (route.valid && !route.fifo);
  wake_c: cover property (wake_detect && cfg_b.wake_line_filter_sel);
endmodule
`default_nettype wire

// ===== include/cbt_pkg.sv
`default_nettype none
package cbt_pkg;
  localparam int CLK_NS       = 50;
  localparam int WAKE_FILT_NS = 500;
  // least filter time, rounded up to whole cycles
  localparam int WAKE_FILT_CYC = (WAKE_FILT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [4:0] INFO_PROC_QUANTA = 5'h02;
  localparam logic [4:0] WAKE_CNT_MAX = 5'(WAKE_FILT_CYC);

  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_ERRCNT = 8'h00;
  localparam logic [7:0] OFF_CFG_A  = 8'h04;
  localparam logic [7:0] OFF_CFG_B  = 8'h08;
  localparam logic [7:0] OFF_FEN    = 8'h0C;
  localparam logic [7:0] OFF_DEST0  = 8'h10;
  localparam logic [7:0] OFF_DEST3  = 8'h1C;
  localparam logic [7:0] OFF_HIT    = 8'h20;

  localparam logic [15:0] CFG_A_RST   = 16'h0000;
  localparam logic [15:0] CFG_B_RST   = 16'h0000;
  localparam logic [15:0] FEN_RST     = 16'hFFFF;
  localparam logic [15:0] DEST_RST    = 16'h0000;
  localparam logic [15:0] CFG_A_WMASK = 16'h00FF;
  localparam logic [15:0] CFG_B_WMASK = 16'h47FF;
  localparam logic [15:0] ALL_WMASK   = 16'hFFFF;

  localparam int NUM_FILT = 16;
  localparam int NUM_DEST_REG = 4;
  localparam logic [3:0] DEST_FIFO = 4'hF;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] unused;
    logic [1:0] resync_jump_len;
    logic [5:0] quantum_prescaler;
  } cbt_cfg_a_t;

  typedef struct packed {
    logic       unused_hi;
    logic       wake_line_filter_sel;
    logic [2:0] unused_mid;
    logic [2:0] phase_two_len;
    logic       phase_two_free_sel;
    logic       triple_sample_sel;
    logic [2:0] phase_one_len;
    logic [2:0] propagation_len;
  } cbt_cfg_b_t;

  typedef struct packed {
    cbt_cfg_a_t a;
    cbt_cfg_b_t b;
  } cbt_timing_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] dest;
    logic       fifo;
  } cbt_route_t;

  // a code n means n+1 quanta
  function automatic logic [4:0] cbt_quanta(input logic [2:0] code);
    return {2'h0, code} + 5'h01;
  endfunction
endpackage
`default_nettype wire

// ===== rtl/cbt_bit_timer.sv
`timescale 1ns/10ps
`default_nettype none
module cbt_bit_timer (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire cbt_pkg::cbt_timing_t timing,
  input  wire logic               rx_line,
  output logic                    tq_tick,
  output logic                    sample_pt,
  output logic                    bit_end,
  output logic                    bus_bit,
  output logic                    wake_detect,
  output logic [4:0]              phase_two_eff
);
  import cbt_pkg::*;

  logic [6:0] pre_cnt;
  logic [6:0] pre_top;
  logic [4:0] q_cnt;
  logic [4:0] prop_q;
  logic [4:0] p1_q;
  logic [4:0] jump_q;
  logic [4:0] bit_len;
  logic [4:0] samp_idx;
  logic [1:0] hist;
  logic       rx_d;
  logic       edge_seen;
  logic       resynced;
  logic [4:0] wake_cnt;

  assign pre_top  = {timing.a.quantum_prescaler, 1'b1};  // [RULE4]
  assign tq_tick  = (pre_cnt == pre_top);
  assign prop_q   = cbt_quanta(timing.b.propagation_len);  // [RULE9]
  assign p1_q     = cbt_quanta(timing.b.phase_one_len);  // [RULE8]
  assign jump_q   = {3'h0, timing.a.resync_jump_len} + 5'h01;  // [RULE3]
  assign samp_idx = prop_q + p1_q;  // [RULE15]
  assign bit_len  = 5'h01 + prop_q + p1_q + phase_two_eff;  // [RULE15]
  assign edge_seen = rx_d && !rx_line && !resynced;

  always_comb begin
    if (timing.b.phase_two_free_sel) begin
      phase_two_eff = cbt_quanta(timing.b.phase_two_len);  // [RULE5] [RULE6]
    end else begin
      phase_two_eff = (p1_q > INFO_PROC_QUANTA) ? p1_q : INFO_PROC_QUANTA;  // [RULE6]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_cnt <= 7'h00;
    end else if (tq_tick || pre_cnt > pre_top) begin
      pre_cnt <= 7'h00;
    end else begin
      pre_cnt <= pre_cnt + 7'h01;
    end
  end

  // one resync per bit; late edge stretches, early edge shortens by the jump width
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_cnt <= 5'h00;
      resynced <= 1'b0;
    end else if (edge_seen && q_cnt != 5'h00) begin
      resynced <= 1'b1;
      if (q_cnt > samp_idx) begin
        q_cnt <= (bit_len - q_cnt <= jump_q) ? 5'h00 : q_cnt + jump_q;  // [RULE3]
      end else begin
        q_cnt <= (q_cnt > jump_q) ? q_cnt - jump_q : 5'h01;  // [RULE3]
      end
    end else if (tq_tick) begin
      if (q_cnt >= bit_len - 5'h01) begin
        q_cnt <= 5'h00;
        resynced <= 1'b0;
      end else begin
        q_cnt <= q_cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_d <= 1'b1;
      hist <= 2'h3;
      sample_pt <= 1'b0;
      bit_end <= 1'b0;
      bus_bit <= 1'b1;
    end else begin
      rx_d <= rx_line;
      sample_pt <= tq_tick && q_cnt == samp_idx;
      bit_end <= tq_tick && q_cnt >= bit_len - 5'h01;
      if (tq_tick) begin
        hist <= {hist[0], rx_line};
      end
      if (tq_tick && q_cnt == samp_idx) begin
        if (timing.b.triple_sample_sel) begin
          bus_bit <= (hist[1] & hist[0]) | (hist[1] & rx_line) | (hist[0] & rx_line);  // [RULE7]
        end else begin
          bus_bit <= rx_line;  // [RULE7]
        end
      end
    end
  end

  // dominant must persist through the filter before it counts as wake
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_cnt <= 5'h00;
      wake_detect <= 1'b0;
    end else begin
      if (rx_line) begin
        wake_cnt <= 5'h00;
      end else if (wake_cnt != WAKE_CNT_MAX) begin
        wake_cnt <= wake_cnt + 5'h01;
      end
      wake_detect <= timing.b.wake_line_filter_sel ? (wake_cnt == WAKE_CNT_MAX) : !rx_line;  // [RULE10]
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  single_sample_a: assert property (  // [RULE7]
    tq_tick && q_cnt == samp_idx && !edge_seen && !timing.b.triple_sample_sel
    |=> sample_pt && bus_bit == $past(rx_line))
    else $error("single sample mismatch");
  phase_two_a: assert property (!timing.b.phase_two_free_sel  // [RULE6]
    |-> phase_two_eff >= p1_q && phase_two_eff >= INFO_PROC_QUANTA
        && (phase_two_eff == p1_q || phase_two_eff == INFO_PROC_QUANTA))
    else $error("phase two length wrong");
  wake_bypass_a: assert property (!timing.b.wake_line_filter_sel  // [RULE10]
    ##1 !timing.b.wake_line_filter_sel |-> wake_detect == !$past(rx_line))
    else $error("wake bypass wrong");
  triple_hit_c: cover property (sample_pt && timing.b.triple_sample_sel);
endmodule
`default_nettype wire

// ===== dv/cbt_can_line.sv
`timescale 1ns/10ps
`default_nettype none
module cbt_can_line (
  input  wire logic clk,
  output logic      can_rx
);
  // idle line is recessive: the transceiver pulls it high between frames
  initial can_rx = 1'h1;

  task automatic dominant(input int cycles);
    can_rx <= 1'h0;
    repeat (cycles) @(posedge clk);
    can_rx <= 1'h1;
  endtask
endmodule
`default_nettype wire

// ===== dv/can_bit_timing_filter_routing_bench.sv
`timescale 1ns/10ps
`default_nettype none
module can_bit_timing_filter_routing_bench;
  import cbt_pkg::*;
  typedef struct {
    logic [7:0]  a;
    logic [31:0] d;
    logic [3:0]  s;
    bit          wr;
    logic [1:0]  br;
    logic [31:0] rd;
    logic [1:0]  rr;
  } cbt_row_t;

  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'h0;
  logic        wvalid = 1'h0;
  logic        bready = 1'h0;
  logic        arvalid = 1'h0;
  logic        rready = 1'h0;
  logic        hit_valid = 1'h0;
  logic [3:0]  hit_index = 4'h0;
  logic [7:0]  txt = 8'hA5;
  logic [7:0]  rxt = 8'h3C;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        can_rx, tq_tick, bit_end, wake_detect, sample_pt;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] fen;
  logic [4:0]  mfi, ph2;
  cbt_route_t  route;
  int          failures = 0;
  int          n_tests = 0;
  int          pre[4] = '{1, 0, 2, 63};
  int          pr[4] = '{2, 0, 0, 0};
  int          p1[4] = '{3, 0, 5, 0};
  int          p2[4] = '{4, 7, 1, 0};
  int          fr[4] = '{1, 0, 0, 1};
  cbt_row_t    rows[12] = '{
    '{8'h00, 32'h1, 4'h3, 1, RESP_SLVERR, 32'h0000A53C, RESP_OKAY},
    '{8'h04, 32'h0, 4'h0, 0, RESP_OKAY, 32'h0, RESP_OKAY},
    '{8'h08, 32'h0, 4'h0, 0, RESP_OKAY, 32'h0, RESP_OKAY},
    '{8'h0C, 32'h0, 4'h0, 0, RESP_OKAY, 32'hFFFF, RESP_OKAY},
    '{8'h10, 32'h0, 4'h0, 0, RESP_OKAY, 32'h0, RESP_OKAY},
    '{8'h1C, 32'h0, 4'h0, 0, RESP_OKAY, 32'h0, RESP_OKAY},
    '{8'h20, 32'h0, 4'h0, 0, RESP_OKAY, 32'h0, RESP_OKAY},
    '{8'h04, 32'hFFFFFFFF, 4'hF, 1, RESP_OKAY, 32'h00FF, RESP_OKAY},
    '{8'h08, 32'hFFFFFFFF, 4'hF, 1, RESP_OKAY, 32'h47FF, RESP_OKAY},
    '{8'h0C, 32'h0, 4'h1, 1, RESP_OKAY, 32'hFF00, RESP_OKAY},
    '{8'h14, 32'hABCD, 4'h2, 1, RESP_OKAY, 32'hAB00, RESP_OKAY},
    '{8'h24, 32'h1, 4'hF, 1, RESP_SLVERR, 32'h0, RESP_SLVERR}
  };

  always #25 clk = ~clk;

  cbt_can_line u_bus (.clk(clk), .can_rx(can_rx));

  cbt_regs u_dut (
    .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .can_rx(can_rx), .tx_fault_tally(txt),
    .rx_fault_tally(rxt), .hit_valid(hit_valid), .hit_index(hit_index), .filter_accept_enable(fen),
    .route(route), .matched_filter_index(mfi), .timing(), .tq_tick(tq_tick), .sample_pt(sample_pt),
    .bit_end(bit_end), .bus_bit(), .wake_detect(wake_detect), .phase_two_eff(ph2)
  );

  task automatic test_done;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask

  // each bus task opens on a fresh edge so a strobe is never lowered and raised in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    bit aw_ok;
    bit w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (awvalid && awready) begin
        aw_ok = 1;
        awvalid <= 1'h0;
      end
      if (wvalid && wready) begin
        w_ok = 1;
        wvalid <= 1'h0;
      end
    end
    do @(posedge clk); while (!bvalid);
    r = bresp;
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask

  task automatic hit(input logic [3:0] idx, input logic [10:0] e);
    @(posedge clk);
    hit_valid <= 1'h1;
    hit_index <= idx;
    @(posedge clk);
    hit_valid <= 1'h0;
    @(negedge clk);
    chk({route.valid, route.fifo, route.dest, mfi}, e);
  endtask

  // first span after a config change may be partial, so callers take the second
  task automatic gap(input bit which, output int n);
    n = 0;
    do @(posedge clk); while (!(which ? bit_end : tq_tick));
    do begin
      @(posedge clk);
      n++;
    end while (!(which ? bit_end : tq_tick));
  endtask

  // cycles from a sample point pulse to the following bit end pulse
  task automatic span(output int n);
    n = 0;
    do @(posedge clk); while (!sample_pt);
    do begin
      @(posedge clk);
      n++;
    end while (!bit_end);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    test_done();
  end

  initial begin
    logic [1:0]  r;
    logic [31:0] d;
    logic [15:0] v;
    int          e2;
    int          n;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr(rows[i].a, rows[i].d, rows[i].s, r);
        chk(r, rows[i].br);
      end
      rd(rows[i].a, d, r);
      chk({d, r}, {rows[i].rd, rows[i].rr});
    end
    wr(OFF_FEN, 32'hFFFF, 4'h3, r);
    for (int k = 0; k < NUM_DEST_REG; k++) begin
      for (int j = 0; j < 4; j++)
        v[4*j+:4] = 4'(15 - 4*k - j);
      wr(OFF_DEST0 + 8'(4*k), {16'h0, v}, 4'h3, r);
    end
    for (int i = 0; i < NUM_FILT; i++)
      hit(4'(i), {1'h1, i == 0, 4'(15 - i), 5'(i)});
    wr(OFF_FEN, 32'hFFF7, 4'h3, r);
    hit(4'h3, {1'h0, 1'h0, 4'h0, 5'h0F});
    for (int t = 0; t < 4; t++) begin
      wr(OFF_CFG_A, {26'h0, 6'(pre[t])}, 4'h3, r);
      wr(OFF_CFG_B, {21'h0, 3'(p2[t]), 1'(fr[t]), 1'h0, 3'(p1[t]), 3'(pr[t])}, 4'h3, r);
      e2 = fr[t] ? p2[t] + 1 : ((p1[t] + 1 > INFO_PROC_QUANTA) ? p1[t] + 1 : INFO_PROC_QUANTA);
      chk(ph2, e2);
      gap(0, n);
      gap(0, n);
      chk(n, 2 * (pre[t] + 1));
      gap(1, n);
      gap(1, n);
      chk(n, 2 * (pre[t] + 1) * (3 + pr[t] + p1[t] + e2));
      span(n);
      chk(n, 2 * (pre[t] + 1) * e2);
    end
    wr(OFF_CFG_B, 32'h4000, 4'h3, r);
    @(posedge clk);
    u_bus.dominant(WAKE_FILT_CYC / 2);
    @(negedge clk);
    chk(wake_detect, 1'h0);
    @(posedge clk);
    u_bus.dominant(2 * WAKE_FILT_CYC);
    @(negedge clk);
    chk(wake_detect, 1'h1);
    @(posedge clk);
    rst <= 1'h1;
    @(posedge clk);
    rst <= 1'h0;
    @(negedge clk);
    chk(wake_detect, 1'h0);
    rd(OFF_FEN, d, r);
    chk(d, 32'hFFFF);
    rd(OFF_CFG_B, d, r);
    chk(d, 32'h0);
    @(posedge clk);
    u_bus.dominant(WAKE_FILT_CYC / 2);
    @(negedge clk);
    chk(wake_detect, 1'h1);
    test_done();
  end
endmodule
`default_nettype wire
